//--- tpt_host.sv
// Host model driving the serial register port of the power table in mode 0.
// Assumes the bench calls its tasks; the link clock stands still between frames.
module tpt_host (
   output logic sclk,
   output logic chip_select_n,
   output logic si,
   input wire logic so
);
   timeunit 1ns;
   timeprecision 100ps;
   // Select rises at 1 ns so the link logic is waiting for its clearing edge
   initial begin
      sclk = 1'b0;
      si = 1'b0;
      #1 chip_select_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         #16 sclk = 1'b1;
         rx[i] = so;
         #16 sclk = 1'b0;
      end
   endtask : xfer
   task open_cs;
      chip_select_n = 1'b0;
      #20;
   endtask : open_cs
   task close_cs;
      #20 chip_select_n = 1'b1;
      // Released line must not keep showing the last bit
      si = ~si;
      // Deselect gap: a back-to-back select would merge into a zero-width pulse
      #40;
   endtask : close_cs
   task frame(input logic [7:0] hdr, input int n, inout logic [7:0] d [8], input bit hold);
      logic [7:0] junk;
      open_cs();
      xfer(hdr, junk);
      for (int k = 0; k < n; k++) xfer(d[k], d[k]);
      if (!hold) close_cs();
   endtask : frame
endmodule : tpt_host

//--- tpt_pkg.sv
// Package for the transmit power level table block.
// Assumes one core clock domain and one serial link clock domain.
package tpt_pkg;

   // Register addresses carried in the header byte
   localparam logic [5:0] CFG_ADDR = 6'h10;
   localparam logic [5:0] TABLE_ADDR = 6'h11;
   localparam logic [5:0] PD_STROBE_ADDR = 6'h12;

   // Header byte layout
   localparam int HDR_READ_BIT = 7;
   localparam int HDR_BURST_BIT = 6;

   // Table geometry, values after reset and the last bit index of a byte
   localparam int TABLE_DEPTH = 8;
   localparam logic [7:0] TABLE0_RESET = 8'hc6;
   localparam logic [7:0] TABLE_OTHER_RESET = 8'h00;
   localparam logic [2:0] PA_SEL_RESET = 3'h0;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // Field of the front-end config register
   localparam int PA_SEL_MSB = 2;

   typedef enum logic [1:0] {
      TPT_ACTIVE = 2'b00,
      TPT_ARMED = 2'b01,
      TPT_ASLEEP = 2'b10
   } tpt_pwr_state_t;

   // One register write handed from the link to the core
   typedef struct packed {
      logic [5:0] addr;
      logic [2:0] idx;
      logic [7:0] data;
   } tpt_wr_t;

endpackage : tpt_pkg

//--- tpt_power_table.sv
// Transmit power level table with its serial register port and sleep control.
// Assumes mode 0 serial timing: input sampled on the rising link clock edge,
// output changed on the falling edge. The link clock only runs while selected.

////////////////////////////////////////////////////////////////////////////////

module tpt_power_table (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic ook_mode,
   input wire logic tx_symbol,
   output logic [7:0] pa_level,
   output logic core_power_en,
   output logic xosc_en
);

   ////////////////////////////////////////////////////////////////////////////
   // Core-domain storage

   logic [7:0] output_power_table [tpt_pkg::TABLE_DEPTH];
   logic [2:0] power_select_index;
   tpt_pkg::tpt_pwr_state_t pwr_state;

   // Read value for the link; core registers only change on link writes and the sleep clear,
   // which never overlap the byte being shifted out, so they are quasi-static
   function automatic logic [7:0] rd_val(input logic [5:0] addr, input logic [2:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (addr == tpt_pkg::CFG_ADDR) begin
         v = {5'h00, power_select_index};
      end else if (addr == tpt_pkg::TABLE_ADDR) begin
         v = output_power_table[idx];
      end
      return v;
   endfunction : rd_val

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: byte assembly, held clear while deselected

   logic [2:0] bit_cnt;
   logic [6:0] rx_shift;
   logic hdr_done;
   logic [7:0] hdr;
   logic [2:0] ptr;
   logic [7:0] tx_byte;
   logic [7:0] byte_in;
   logic byte_done;
   logic wr_fire;
   logic pd_fire;
   logic [2:0] next_ptr;

   assign byte_in = {rx_shift, si};
   assign byte_done = (bit_cnt == tpt_pkg::LAST_BIT);
   assign wr_fire = byte_done && hdr_done && !hdr[tpt_pkg::HDR_READ_BIT];
   assign pd_fire = byte_done && !hdr_done && (byte_in[5:0] == tpt_pkg::PD_STROBE_ADDR);
   // Only a burst advances the table pointer; a single access always hits entry zero
   assign next_ptr = (hdr[tpt_pkg::HDR_BURST_BIT] && hdr[5:0] == tpt_pkg::TABLE_ADDR) ?
                     3'(ptr + 3'h1) : ptr;

   always_ff @(posedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         bit_cnt <= 3'h0;
         rx_shift <= 7'h00;
         hdr_done <= 1'b0;
         hdr <= 8'h00;
         ptr <= 3'h0;
         tx_byte <= 8'h00;
      end else begin
         bit_cnt <= 3'(bit_cnt + 3'h1);
         rx_shift <= byte_in[6:0];
         if (byte_done) begin
            if (!hdr_done) begin
               hdr_done <= 1'b1;
               hdr <= byte_in;
               tx_byte <= byte_in[tpt_pkg::HDR_READ_BIT] ? rd_val(byte_in[5:0], ptr) : 8'h00;
            end else begin
               ptr <= next_ptr;
               tx_byte <= hdr[tpt_pkg::HDR_READ_BIT] ? rd_val(hdr[5:0], next_ptr) : 8'h00;
            end
         end
      end
   end

   // Status during the header is all zero, so the line reads low as ready
   always_ff @(negedge sclk or posedge chip_select_n) begin
      if (chip_select_n) begin
         so <= 1'b0;
      end else begin
         so <= tx_byte[3'(tpt_pkg::LAST_BIT - bit_cnt)];
      end
   end

   assign so_oe = !chip_select_n;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: events toward the core, kept across deselect

   tpt_pkg::tpt_wr_t wr_word;
   logic wr_tgl;
   logic pd_tgl;

   // The word is held for at least a byte time, far longer than the sync delay
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         wr_word <= '0;
         wr_tgl <= 1'b0;
         pd_tgl <= 1'b0;
      end else begin
         if (wr_fire) begin
            wr_word <= '{addr: hdr[5:0], idx: ptr, data: byte_in};
            wr_tgl <= !wr_tgl;
         end
         if (pd_fire) begin
            pd_tgl <= !pd_tgl;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crossings into the core domain

   logic [2:0] wr_sync;
   logic [2:0] pd_sync;
   logic [1:0] cs_sync;
   logic wr_evt;
   logic pd_evt;
   logic cs_hi;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wr_sync <= 3'h0;
         pd_sync <= 3'h0;
         cs_sync <= 2'h3;
      end else begin
         wr_sync <= {wr_sync[1:0], wr_tgl};
         pd_sync <= {pd_sync[1:0], pd_tgl};
         cs_sync <= {cs_sync[0], chip_select_n};
      end
   end

   assign wr_evt = wr_sync[2] ^ wr_sync[1];
   assign pd_evt = pd_sync[2] ^ pd_sync[1];
   assign cs_hi = cs_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // Power-down sequencing

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pwr_state <= tpt_pkg::TPT_ACTIVE;
      end else begin
         case (pwr_state)
            tpt_pkg::TPT_ACTIVE: begin
               if (pd_evt) begin
                  pwr_state <= tpt_pkg::TPT_ARMED;
               end
            end
            tpt_pkg::TPT_ARMED: begin
               if (cs_hi) begin
                  pwr_state <= tpt_pkg::TPT_ASLEEP;
               end
            end
            tpt_pkg::TPT_ASLEEP: begin
               if (!cs_hi) begin
                  pwr_state <= tpt_pkg::TPT_ACTIVE;
               end
            end
            default: begin
               pwr_state <= tpt_pkg::TPT_ACTIVE;
            end
         endcase
      end
   end

   // Power stays on while armed, so the strobe's own transfer can finish
   assign core_power_en = (pwr_state != tpt_pkg::TPT_ASLEEP);
   assign xosc_en = (pwr_state != tpt_pkg::TPT_ASLEEP);

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   function automatic logic wr_sync_addr_is(input logic [5:0] a);
      return wr_word.addr == a;
   endfunction : wr_sync_addr_is

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         power_select_index <= tpt_pkg::PA_SEL_RESET;
      end else if (wr_evt && wr_sync_addr_is(tpt_pkg::CFG_ADDR)) begin
         power_select_index <= wr_word.data[tpt_pkg::PA_SEL_MSB:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         for (int i = 0; i < tpt_pkg::TABLE_DEPTH; i++) begin
            output_power_table[i] <= tpt_pkg::TABLE_OTHER_RESET;
         end
         output_power_table[0] <= tpt_pkg::TABLE0_RESET;
      end else if (pwr_state == tpt_pkg::TPT_ARMED && cs_hi) begin
         // Only entry zero survives sleep
         for (int i = 1; i < tpt_pkg::TABLE_DEPTH; i++) begin
            output_power_table[i] <= tpt_pkg::TABLE_OTHER_RESET;
         end
      end else if (wr_evt && wr_sync_addr_is(tpt_pkg::TABLE_ADDR)) begin
         output_power_table[wr_word.idx] <= wr_word.data[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Amplifier level selection

   logic [2:0] next_sel;

   always_comb begin
      next_sel = power_select_index;
      if (ook_mode && !tx_symbol) begin
         next_sel = 3'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pa_level <= tpt_pkg::TABLE0_RESET;
      end else begin
         pa_level <= output_power_table[next_sel];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   fsk_entry0_a: assert property (@(posedge mclk) disable iff (!nrst)
      !ook_mode && power_select_index == 3'h0 |=> pa_level == $past(output_power_table[0]))
      else $error("fsk level not from entry zero");

   ook_levels_a: assert property (@(posedge mclk) disable iff (!nrst)
      ook_mode && power_select_index == 3'h1 |=>
      pa_level == ($past(tx_symbol) ? $past(output_power_table[1]) : $past(output_power_table[0])))
      else $error("ook level does not follow symbol");

   sel_reset_a: assert property (@(posedge mclk)
      !nrst |=> power_select_index == 3'h0)
      else $error("power select not zero after reset");

   entry_write_a: assert property (@(posedge mclk) disable iff (!nrst)
      wr_evt && wr_word.addr == tpt_pkg::TABLE_ADDR && !(pwr_state == tpt_pkg::TPT_ARMED && cs_hi)
      |=> output_power_table[$past(wr_word.idx)] == $past(wr_word.data))
      else $error("table entry write lost");

   sleep_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
      pwr_state == tpt_pkg::TPT_ARMED && cs_hi |=>
      output_power_table[0] == $past(output_power_table[0]) && output_power_table[1] == 8'h00
      && pwr_state == tpt_pkg::TPT_ASLEEP)
      else $error("sleep entry did not keep entry zero only");

   power_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      pwr_state == tpt_pkg::TPT_ACTIVE && pd_evt ##1 !cs_hi[*2] |-> core_power_en)
      else $error("power dropped while still selected");

   wake_up_a: assert property (@(posedge mclk) disable iff (!nrst)
      pwr_state == tpt_pkg::TPT_ASLEEP && !cs_hi |=> core_power_en && xosc_en)
      else $error("select low did not restore power");

   entry0_reset_a: assert property (@(posedge mclk)
      !nrst |=> output_power_table[0] == 8'hc6 && pa_level == 8'hc6)
      else $error("entry zero reset value wrong");

   indexed_sel_a: assert property (@(posedge mclk) disable iff (!nrst)
      !ook_mode && power_select_index > 3'h1 |=> pa_level == $past(output_power_table[power_select_index]))
      else $error("level not from indexed entry");

   // OOK zero symbols fall back to entry zero whatever the select holds
   ook_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
      ook_mode && !tx_symbol |=> pa_level == $past(output_power_table[0]))
      else $error("ook zero symbol not from entry zero");

   strobe_arm_a: assert property (@(posedge mclk) disable iff (!nrst)
      pwr_state == tpt_pkg::TPT_ACTIVE && pd_evt |=> pwr_state == tpt_pkg::TPT_ARMED)
      else $error("power-down strobe not armed");

   armed_power_a: assert property (@(posedge mclk) disable iff (!nrst)
      pwr_state == tpt_pkg::TPT_ARMED && !cs_hi |=> core_power_en && xosc_en)
      else $error("power dropped before deselect");

endmodule : tpt_power_table

//--- tpt_power_table_tb.sv
// Self-checking bench for the transmit power table.
// Assumes the host model in tpt_host.sv; core inputs change on falling mclk.
module tpt_power_table_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, nrst, ook_mode, tx_symbol, so, so_oe, core_power_en, xosc_en, sclk, chip_select_n, si;
   logic [7:0] pa_level;
   logic [7:0] exp_tab [8];
   logic [7:0] buf8 [8];
   int bad_count, compares, seed;
   tpt_power_table i_dut (.mclk(mclk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n), .si(si),
      .so(so), .so_oe(so_oe), .ook_mode(ook_mode), .tx_symbol(tx_symbol), .pa_level(pa_level),
      .core_power_en(core_power_en), .xosc_en(xosc_en));
   tpt_host i_host (.sclk(sclk), .chip_select_n(chip_select_n), .si(si), .so(so));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("Mismatches %0d of %0d compares", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   task check8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t byte %h want %h", $time, got, exp);
      end
   endtask : check8
   task check1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t bit %b want %b", $time, got, exp);
      end
   endtask : check1
   function logic [7:0] pick(input logic [2:0] p, input logic ook, input logic sym);
      return (ook && !sym) ? exp_tab[0] : exp_tab[p];
   endfunction : pick
   task wait_level(input logic [7:0] e);
      for (int n = 0; n < 20 && pa_level !== e; n++) @(negedge mclk);
      check8(pa_level, e);
      if (pa_level !== e) finish_test();
   endtask : wait_level
   task wait_pwr(input logic e);
      for (int n = 0; n < 20 && core_power_en !== e; n++) @(negedge mclk);
      check1(core_power_en, e);
      check1(xosc_en, e);
      if (core_power_en !== e) finish_test();
   endtask : wait_pwr
   task read_table;
      i_host.frame(8'hd1, 8, buf8, 0);
      for (int k = 0; k < 8; k++) check8(buf8[k], exp_tab[k]);
   endtask : read_table
   initial begin
      #200000;
      bad_count++;
      finish_test();
   end
   initial begin
      seed = 43;
      nrst = 1'b1;
      ook_mode = 1'b0;
      tx_symbol = 1'b0;
      buf8 = '{default: 8'h00};
      exp_tab = '{8'hc6, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      // Falling edge at 1 ns so the asynchronous toggle clear is seen
      #1 nrst = 1'b0;
      repeat (6) @(negedge mclk);
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      check8(pa_level, 8'hc6);
      i_host.frame(8'h90, 1, buf8, 0);
      check8(buf8[0], 8'h00);
      read_table();
      for (int k = 0; k < 8; k++) buf8[k] = 8'($random(seed));
      exp_tab = buf8;
      i_host.frame(8'h51, 8, buf8, 0);
      read_table();
      buf8[0] = 8'hff;
      exp_tab[0] = 8'hff;
      i_host.frame(8'h11, 1, buf8, 0);
      buf8[0] = 8'h5a;
      i_host.frame(8'h13, 1, buf8, 0);
      i_host.frame(8'h93, 1, buf8, 0);
      check8(buf8[0], 8'h00);
      read_table();
      for (int p = 0; p < 8; p++) begin
         buf8[0] = {5'h00, p[2:0]};
         i_host.frame(8'h10, 1, buf8, 0);
         for (int m = 0; m < 6; m++) begin
            @(negedge mclk);
            ook_mode = (m < 4) ? m[1] : 1'($random(seed));
            tx_symbol = (m < 4) ? m[0] : 1'($random(seed));
            wait_level(pick(p[2:0], ook_mode, tx_symbol));
         end
      end
      i_host.frame(8'h12, 0, buf8, 1);
      repeat (10) @(negedge mclk);
      check1(core_power_en, 1'b1);
      check1(so_oe, 1'b1);
      i_host.close_cs();
      wait_pwr(1'b0);
      check1(so_oe, 1'b0);
      i_host.open_cs();
      wait_pwr(1'b1);
      i_host.close_cs();
      for (int k = 1; k < 8; k++) exp_tab[k] = 8'h00;
      read_table();
      wait_level(pick(3'h7, ook_mode, tx_symbol));
      // Second reset in mid-run must bring back the power-on values
      @(negedge mclk);
      ook_mode = 1'b0;
      nrst = 1'b0;
      repeat (6) @(negedge mclk);
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      check8(pa_level, 8'hc6);
      i_host.frame(8'h90, 1, buf8, 0);
      check8(buf8[0], 8'h00);
      exp_tab[0] = 8'hc6;
      read_table();
      finish_test();
   end
endmodule : tpt_power_table_tb
